// file: fsps_pkg.sv
// package: constants and types for the flash self-program sequencer
package fsps_pkg;
	// store-control register bit positions
	localparam int BIT_EN     = 0;
	localparam int BIT_ERASE  = 1;
	localparam int BIT_WRITE  = 2;
	localparam int BIT_LOCK   = 3;
	localparam int BIT_REEN   = 4;
	localparam int BIT_BUSY   = 6;
	localparam int BIT_IE     = 7;
	// accepted command patterns, low five bits
	localparam logic [4:0] CMD_LOAD  = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_LOCK  = 5'h09;
	localparam logic [4:0] CMD_REEN  = 5'h11;
	// timed windows in cycles
	localparam logic [2:0] STORE_WIN = 3'h4;
	localparam logic [2:0] LOAD_WIN  = 3'h3;
	// fuse / lock read pointers
	localparam logic [15:0] PTR_FUSE_LO = 16'h0000;
	localparam logic [15:0] PTR_LOCK    = 16'h0001;
	localparam logic [15:0] PTR_FUSE_EX = 16'h0002;
	localparam logic [15:0] PTR_FUSE_HI = 16'h0003;
	localparam logic [7:0]  ALL_ONES    = 8'hFF;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	// programming time
	localparam int PROG_MIN_US = 3700;
	localparam int PROG_MAX_US = 4500;
	localparam int CLK_MHZ     = 100;
	localparam int PROG_CYCLES = (PROG_MIN_US + PROG_MAX_US) / 2 * CLK_MHZ;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARM  = 2'b01,
		ST_PROG = 2'b11
	} fsps_state_t;
	typedef struct packed {
		logic [15:0] ptr;
		logic [7:0]  lo;
		logic [7:0]  hi;
	} fsps_cpu_t;
endpackage

// file: fsps_seq.sv
// flash self-program sequencer top module
`timescale 1ns/1ns
//
// Contract
// - erase command then store instruction within four cycles erases page
// - programming no-rww section halts cpu; rww target leaves other readable
// - write command then store instruction within four cycles writes page
// - load command stores data pair in buffer word selected by pointer
// - buffer cleared after page write, on re-enable, and at reset
// - eeprom write during loading discards loaded buffer data
// - completion interrupt asserted while enabled and enable bit low
// - rww section blocked and busy flag set during erase or write
// - lock command then store instruction sets boot lock bits from low data
// - zeros in low data bits 5..2 program boot lock bits
// - lock-bit programming blocks no flash section
// - eeprom write blocks flash programming and fuse/lock reads
// - lock command then load instruction within three cycles reads lock byte
// - lock-set and enable clear after read or missed windows
// - fuse read pointers 0, 3, 2 give low, high, extended fuses
// - read fuse and lock bits show zero when programmed
// - enable bit stays set through erase or write, then clears
// - other command patterns have no effect
// - each programming operation lasts between 3.7 and 4.5 ms
module fsps_seq #(
	parameter int WORDS_PER_PAGE = 128,
	parameter int PAGE_BITS      = 8,
	parameter int NO_READ_WHILE_WRITE_SECTION_FIRST     = 192,
	parameter int PROG_CYCLES    = fsps_pkg::PROG_CYCLES,
	parameter logic [7:0] FUSE_LO_INIT = 8'hE1,
	parameter logic [7:0] FUSE_HI_INIT = 8'h99,
	parameter logic [7:0] FUSE_EX_INIT = 8'hFF
) (
	// clock, reset, enable
	input  wire logic                 i_mclk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_ce,
	// store-control register access
	input  wire logic                 i_ctrl_wr,
	input  wire logic [7:0]           i_ctrl_wdata,
	output logic [7:0]                o_ctrl_rdata,
	// instruction strobes and operands
	input  wire logic                 i_store_instr,
	input  wire logic                 i_load_instr,
	input  wire fsps_pkg::fsps_cpu_t  i_cpu,
	input  wire logic                 i_eeprom_write_strobe,
	// results
	output logic                      o_load_valid,
	output logic [7:0]                o_load_data,
	output logic                      o_cpu_halt,
	output logic                      o_rww_block,
	output logic                      o_irq,
	// flash array side
	output logic                      o_erase_pulse,
	output logic                      o_write_pulse,
	output logic [PAGE_BITS-1:0]      o_page,
	output logic [WORDS_PER_PAGE*16-1:0] o_page_data,
	output logic [7:0]                o_lock_bits
);
	localparam int WB = $clog2(WORDS_PER_PAGE);
	localparam int CW = $clog2(PROG_CYCLES + 1);

	// ==========================================
	// state
	fsps_pkg::fsps_state_t st_r, st_nxt;
	logic [7:0]             ctl_r, ctl_nxt;
	logic [2:0]             win_r, win_nxt;
	logic [CW-1:0]          cnt_r, cnt_nxt;
	logic [PAGE_BITS-1:0]   page_r, page_nxt;
	logic                   halt_r, halt_nxt;
	logic                   blk_r, blk_nxt;
	logic                   lvalid_r, lvalid_nxt;
	logic [7:0]             ldata_r, ldata_nxt;
	logic [7:0]             lock_r, lock_nxt;
	logic                   ers_r, ers_nxt;
	logic                   wrp_r, wrp_nxt;
	logic                   clr_buf;
	logic                   ld_word;
	logic                   rd_go;
	logic                   lock_wr;
	logic                   cmd_ok;
	logic [15:0]            buf_r [WORDS_PER_PAGE];
	logic [WB-1:0]          widx;
	logic [4:0]             cmd;
	logic [7:0]             fsel;

	assign cmd  = ctl_r[4:0];
	assign widx = i_cpu.ptr[WB:1];

	// ==========================================
	// fuse and lock byte select
	always_comb begin
		case (i_cpu.ptr)
			fsps_pkg::PTR_FUSE_LO: fsel = FUSE_LO_INIT;
			fsps_pkg::PTR_FUSE_HI: fsel = FUSE_HI_INIT;
			fsps_pkg::PTR_FUSE_EX: fsel = {6'h3F, FUSE_EX_INIT[1:0]};
			default:               fsel = {2'h3, lock_r[5:0]};
		endcase
	end

	// ==========================================
	// accepted command patterns
	always_comb begin
		case (i_ctrl_wdata[4:0])
			fsps_pkg::CMD_LOAD,
			fsps_pkg::CMD_ERASE,
			fsps_pkg::CMD_WRITE,
			fsps_pkg::CMD_LOCK,
			fsps_pkg::CMD_REEN: cmd_ok = 1'b1;
			default:            cmd_ok = 1'b0;
		endcase
	end

	// ==========================================
	// sequencer next state
	always_comb begin
		st_nxt     = st_r;
		ctl_nxt    = ctl_r;
		win_nxt    = win_r;
		cnt_nxt    = cnt_r;
		page_nxt   = page_r;
		halt_nxt   = halt_r;
		blk_nxt    = blk_r;
		rd_go      = 1'b0;
		lock_wr    = 1'b0;
		ers_nxt    = 1'b0;
		wrp_nxt    = 1'b0;
		clr_buf    = 1'b0;
		ld_word    = 1'b0;
		case (st_r)
			fsps_pkg::ST_IDLE: begin
				if (i_ctrl_wr) begin
					ctl_nxt[fsps_pkg::BIT_IE] = i_ctrl_wdata[fsps_pkg::BIT_IE];
					if (!i_eeprom_write_strobe && cmd_ok) begin
						ctl_nxt[4:0] = i_ctrl_wdata[4:0];
						win_nxt      = fsps_pkg::STORE_WIN;
						st_nxt       = fsps_pkg::ST_ARM;
					end
				end
			end
			fsps_pkg::ST_ARM: begin
				if (i_eeprom_write_strobe) begin
					ctl_nxt[4:0] = 5'h00;
					st_nxt       = fsps_pkg::ST_IDLE;
				end else if (i_load_instr && cmd == fsps_pkg::CMD_LOCK &&
					win_r > (fsps_pkg::STORE_WIN - fsps_pkg::LOAD_WIN)) begin
					rd_go        = 1'b1;
					ctl_nxt[4:0] = 5'h00;
					st_nxt       = fsps_pkg::ST_IDLE;
				end else if (i_store_instr) begin
					case (cmd)
						fsps_pkg::CMD_LOAD: begin
							ld_word = 1'b1;
							blk_nxt = 1'b0;
							ctl_nxt[4:0] = 5'h00;
							st_nxt  = fsps_pkg::ST_IDLE;
						end
						fsps_pkg::CMD_REEN: begin
							clr_buf = 1'b1;
							blk_nxt = 1'b0;
							ctl_nxt[4:0] = 5'h00;
							st_nxt  = fsps_pkg::ST_IDLE;
						end
						fsps_pkg::CMD_LOCK: begin
							lock_wr = 1'b1;
							cnt_nxt = CW'(PROG_CYCLES);
							st_nxt  = fsps_pkg::ST_PROG;
						end
						default: begin
							page_nxt = i_cpu.ptr[WB+1 +: PAGE_BITS];
							halt_nxt = (i_cpu.ptr[WB+1 +: PAGE_BITS] >= PAGE_BITS'(NO_READ_WHILE_WRITE_SECTION_FIRST));
							blk_nxt  = 1'b1;
							cnt_nxt  = CW'(PROG_CYCLES);
							st_nxt   = fsps_pkg::ST_PROG;
						end
					endcase
				end else if (win_r == 3'h1) begin
					ctl_nxt[4:0] = 5'h00;
					st_nxt       = fsps_pkg::ST_IDLE;
				end else begin
					win_nxt = win_r - 3'h1;
				end
			end
			fsps_pkg::ST_PROG: begin
				if (cnt_r == CW'(1)) begin
					ers_nxt  = (cmd == fsps_pkg::CMD_ERASE);
					wrp_nxt  = (cmd == fsps_pkg::CMD_WRITE);
					clr_buf  = (cmd == fsps_pkg::CMD_WRITE);
					halt_nxt = 1'b0;
					ctl_nxt[4:0] = 5'h00;
					st_nxt   = fsps_pkg::ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - CW'(1);
				end
			end
			default: st_nxt = fsps_pkg::ST_IDLE;
		endcase
		if (i_eeprom_write_strobe && st_r != fsps_pkg::ST_PROG)
			clr_buf = 1'b1;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r     <= fsps_pkg::ST_IDLE;
			ctl_r    <= fsps_pkg::CTRL_RESET;
			win_r    <= 3'h0;
			cnt_r    <= '0;
			page_r   <= '0;
			halt_r   <= 1'b0;
			blk_r    <= 1'b0;
			ers_r    <= 1'b0;
			wrp_r    <= 1'b0;
		end else if (i_ce) begin
			st_r     <= st_nxt;
			ctl_r    <= ctl_nxt;
			win_r    <= win_nxt;
			cnt_r    <= cnt_nxt;
			page_r   <= page_nxt;
			halt_r   <= halt_nxt;
			blk_r    <= blk_nxt;
			ers_r    <= ers_nxt;
			wrp_r    <= wrp_nxt;
		end
	end

	// ==========================================
	// lock byte
	always_comb begin
		lock_nxt = lock_r;
		if (lock_wr)
			lock_nxt[5:2] = lock_r[5:2] & i_cpu.lo[5:2];
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n)
			lock_r <= fsps_pkg::ALL_ONES;
		else if (i_ce)
			lock_r <= lock_nxt;
	end

	// ==========================================
	// fuse and lock read result
	always_comb begin
		lvalid_nxt = rd_go;
		ldata_nxt  = ldata_r;
		if (rd_go)
			ldata_nxt = fsel;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lvalid_r <= 1'b0;
			ldata_r  <= 8'h00;
		end else if (i_ce) begin
			lvalid_r <= lvalid_nxt;
			ldata_r  <= ldata_nxt;
		end
	end

	// ==========================================
	// temporary page buffer
	genvar g;
	generate
		for (g = 0; g < WORDS_PER_PAGE; g++) begin : g_buf
			logic [15:0] w_nxt;
			always_comb begin
				w_nxt = buf_r[g];
				if (clr_buf)
					w_nxt = 16'hFFFF;
				else if (ld_word && widx == WB'(g))
					w_nxt = {i_cpu.hi, i_cpu.lo};
			end
			always_ff @(posedge i_mclk or negedge i_rst_n) begin
				if (!i_rst_n)
					buf_r[g] <= 16'hFFFF;
				else if (i_ce)
					buf_r[g] <= w_nxt;
			end
			assign o_page_data[g*16 +: 16] = buf_r[g];
		end
	endgenerate

	// ==========================================
	// outputs
	always_comb begin
		o_ctrl_rdata = ctl_r;
		o_ctrl_rdata[fsps_pkg::BIT_BUSY] = blk_r;
		o_ctrl_rdata[5] = 1'b0;
	end
	assign o_irq         = ctl_r[fsps_pkg::BIT_IE] && !ctl_r[fsps_pkg::BIT_EN];
	assign o_rww_block   = blk_r;
	assign o_cpu_halt    = halt_r;
	assign o_load_valid  = lvalid_r;
	assign o_load_data   = ldata_r;
	assign o_erase_pulse = ers_r;
	assign o_write_pulse = wrp_r;
	assign o_page        = page_r;
	assign o_lock_bits   = lock_r;
endmodule

// file: fsps_seq_sva.sv
// checker for the flash self-program sequencer ports
`timescale 1ns/1ns
module fsps_seq_sva #(
	parameter int PROG_CYCLES = 20
) (
	// ======== watched ports
	input wire logic                i_mclk,
	input wire logic                i_rst_n,
	input wire logic                i_ce,
	input wire logic                i_ctrl_wr,
	input wire logic [7:0]          i_ctrl_wdata,
	input wire logic [7:0]          o_ctrl_rdata,
	input wire logic                i_store_instr,
	input wire logic                i_load_instr,
	input wire fsps_pkg::fsps_cpu_t i_cpu,
	input wire logic                i_eeprom_write_strobe,
	input wire logic                o_load_valid,
	input wire logic [7:0]          o_load_data,
	input wire logic                o_rww_block,
	input wire logic                o_irq,
	input wire logic                o_erase_pulse,
	input wire logic                o_write_pulse,
	input wire logic [7:0]          o_lock_bits
);
	localparam int LO = PROG_CYCLES - 1;
	localparam int HI = PROG_CYCLES + 1;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	a_irq_level: assert property (o_irq == (o_ctrl_rdata[7] && !o_ctrl_rdata[0]))
		else $error("irq level wrong");
	a_irq_done: assert property ((o_erase_pulse || o_write_pulse) && o_ctrl_rdata[7] |-> o_irq)
		else $error("no completion interrupt");
	a_erase_go: assert property (i_ce && i_store_instr && !i_eeprom_write_strobe && !o_rww_block
		&& o_ctrl_rdata[4:0] == fsps_pkg::CMD_ERASE |=> o_rww_block && o_ctrl_rdata[0]) else $error("erase not begun");
	a_prog_time: assert property ($rose(o_rww_block) |-> ##[LO:HI] (o_erase_pulse || o_write_pulse))
		else $error("programming time wrong");
	a_en_held: assert property ($rose(o_rww_block) |-> o_ctrl_rdata[0] [*8])
		else $error("enable dropped early");
	a_en_clear: assert property (o_erase_pulse || o_write_pulse |=> !o_ctrl_rdata[0])
		else $error("enable not cleared");
	a_cmd_other: assert property (i_ce && i_ctrl_wr && !o_ctrl_rdata[0] && !(i_ctrl_wdata[4:0] inside
		{5'h01, 5'h03, 5'h05, 5'h09, 5'h11}) |=> o_ctrl_rdata[4:0] == 5'h00) else $error("bad command armed");
	a_ee_block: assert property (i_eeprom_write_strobe && i_ctrl_wr |=> o_ctrl_rdata[4:0] == 5'h00)
		else $error("armed during eeprom write");
	a_lock_read: assert property (i_ce && i_load_instr && !i_eeprom_write_strobe && i_cpu.ptr == 16'h0001
		&& o_ctrl_rdata[4:0] == 5'h09 |=> o_load_valid && o_load_data == o_lock_bits) else $error("lock read wrong");
endmodule
bind fsps_seq fsps_seq_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (.i_mclk, .i_rst_n, .i_ce, .i_ctrl_wr, .i_ctrl_wdata,
	.o_ctrl_rdata, .i_store_instr, .i_load_instr, .i_cpu, .i_eeprom_write_strobe, .o_load_valid, .o_load_data,
	.o_rww_block, .o_irq, .o_erase_pulse, .o_write_pulse, .o_lock_bits);

// file: fsps_cpu_model.sv
// cpu core model issuing timed store and load sequences
`timescale 1ns/1ns
module fsps_cpu_model (
	// clock and status
	input  wire logic       i_mclk,
	input  wire logic [7:0] i_ctrl_rdata,
	input  wire logic       i_load_valid,
	input  wire logic [7:0] i_load_data,
	// ======== register write and instructions
	output logic                o_ctrl_wr,
	output logic [7:0]          o_ctrl_wdata,
	output logic                o_store_instr,
	output logic                o_load_instr,
	output fsps_pkg::fsps_cpu_t o_cpu
);
	initial begin
		o_ctrl_wr = 1'b0;
		o_ctrl_wdata = 8'h00;
		o_store_instr = 1'b0;
		o_load_instr = 1'b0;
		o_cpu = '0;
	end
	task automatic op(input logic [7:0] cmd, input logic ld, input int gap, input logic [15:0] ptr,
			input logic [15:0] d, output logic [7:0] rd);
		int n;
		n = 0;
		while (i_ctrl_rdata[0] !== 1'b0 && n < 200) begin
			@(posedge i_mclk);
			#1 n++;
		end
		@(posedge i_mclk);
		o_cpu <= '{ptr: ptr, lo: d[7:0], hi: d[15:8]};
		o_ctrl_wdata <= cmd;
		o_ctrl_wr <= 1'b1;
		@(posedge i_mclk);
		o_ctrl_wr <= 1'b0;
		o_ctrl_wdata <= ~cmd;
		repeat (gap) @(posedge i_mclk);
		o_store_instr <= !ld;
		o_load_instr <= ld;
		@(posedge i_mclk);
		o_store_instr <= 1'b0;
		o_load_instr <= 1'b0;
		#1 rd = i_load_valid ? i_load_data : 8'h00;
	endtask
endmodule

// file: fsps_seq_tb.sv
// testbench for the flash self-program sequencer
`timescale 1ns/1ns
module fsps_seq_tb;
	logic                i_mclk, i_rst_n, i_ce, i_eeprom_write_strobe, i_ctrl_wr, i_store_instr, i_load_instr;
	logic                o_load_valid, o_cpu_halt, o_rww_block, o_irq, o_erase_pulse, o_write_pulse;
	logic [7:0]          i_ctrl_wdata, o_ctrl_rdata, o_load_data, o_lock_bits, rd;
	logic [3:0]          o_page;
	logic [31:0]         o_page_data;
	fsps_pkg::fsps_cpu_t i_cpu;
	int                  mismatches, num_checks, n;
	logic [15:0]         rp [4] = '{16'h0000, 16'h0003, 16'h0002, 16'h0001};
	logic [7:0]          re [4] = '{8'hE1, 8'h99, 8'hFE, 8'hFF};
	logic [7:0]          rm [4] = '{8'hFF, 8'hFF, 8'h03, 8'hFF};
	fsps_seq #(.WORDS_PER_PAGE(2), .PAGE_BITS(4), .NO_READ_WHILE_WRITE_SECTION_FIRST(8), .PROG_CYCLES(20),
		.FUSE_EX_INIT(8'hFE)) u_dut (.i_mclk, .i_rst_n, .i_ce, .i_ctrl_wr, .i_ctrl_wdata,
		.o_ctrl_rdata, .i_store_instr, .i_load_instr, .i_cpu, .i_eeprom_write_strobe, .o_load_valid, .o_load_data,
		.o_cpu_halt, .o_rww_block, .o_irq, .o_erase_pulse, .o_write_pulse, .o_page, .o_page_data, .o_lock_bits);
	fsps_cpu_model u_cpu (.i_mclk, .i_ctrl_rdata(o_ctrl_rdata), .i_load_valid(o_load_valid),
		.i_load_data(o_load_data), .o_ctrl_wr(i_ctrl_wr), .o_ctrl_wdata(i_ctrl_wdata),
		.o_store_instr(i_store_instr), .o_load_instr(i_load_instr), .o_cpu(i_cpu));
	// ======== helpers
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wt(input logic w);
		n = 0;
		while ((w ? o_write_pulse : o_erase_pulse) !== 1'b1 && n < 60) begin
			@(posedge i_mclk);
			#1 n++;
		end
		chk("prog_len", 32'h1, {31'h0, n >= 18 && n <= 22});
	endtask
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	initial begin
		#200000;
		mismatches++;
		complete_run();
	end
	initial begin
		i_rst_n = 1'b0;
		i_ce = 1'b1;
		i_eeprom_write_strobe = 1'b0;
		repeat (12) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		#1 chk("rst", 32'h00FFFFFF, {o_ctrl_rdata, o_lock_bits, o_page_data[15:0]});
		for (int i = 0; i < 4; i++) begin
			u_cpu.op(8'h09, 1'b1, 1, rp[i], 16'h0000, rd);
			chk("fuse_read", {24'h0, re[i] & rm[i]}, {23'h0, o_ctrl_rdata[0], rd & rm[i]});
		end
		$display("test fuse_read done");
		u_cpu.op(8'h01, 1'b0, 0, 16'h0024, 16'h1234, rd);
		u_cpu.op(8'h01, 1'b0, 3, 16'h0026, 16'hABCD, rd);
		chk("buf_fill", 32'hABCD1234, o_page_data);
		u_cpu.op(8'h03, 1'b0, 3, 16'h0024, 16'h0000, rd);
		chk("erase_no_read_while_write_section", 32'h3, {o_cpu_halt, o_rww_block});
		wt(1'b0);
		chk("erase_page", 32'h9, o_page);
		u_cpu.op(8'h85, 1'b0, 0, 16'h0024, 16'h0000, rd);
		wt(1'b1);
		@(posedge i_mclk);
		#1 chk("write_end", 32'h19FFFF, {o_irq, o_page, o_page_data[15:0]});
		u_cpu.op(8'h11, 1'b0, 0, 16'h0000, 16'h0000, rd);
		chk("reenable", 32'h0, o_rww_block);
		$display("test page_cycle done");
		u_cpu.op(8'h03, 1'b0, 0, 16'h0008, 16'h0000, rd);
		chk("erase_rww", 32'h1, {o_cpu_halt, o_rww_block});
		wt(1'b0);
		u_cpu.op(8'h05, 1'b0, 4, 16'h0008, 16'h0000, rd);
		chk("late_store", 32'h0, {o_ctrl_rdata[0], o_write_pulse});
		u_cpu.op(8'h07, 1'b0, 0, 16'h0008, 16'h0000, rd);
		chk("bad_cmd", 32'h0, o_ctrl_rdata[4:0]);
		$display("test window done");
		u_cpu.op(8'h01, 1'b0, 0, 16'h0024, 16'h5555, rd);
		chk("load_busy", 32'hFFFF5555, o_page_data);
		chk("load_unbusy", 32'h0, o_rww_block);
		@(posedge i_mclk);
		i_eeprom_write_strobe <= 1'b1;
		repeat (2) @(posedge i_mclk);
		#1 chk("ee_discard", 32'hFFFFFFFF, o_page_data);
		u_cpu.op(8'h03, 1'b0, 0, 16'h0024, 16'h0000, rd);
		u_cpu.op(8'h09, 1'b1, 0, 16'h0000, 16'h0000, rd);
		chk("ee_block", 32'h0, {rd, o_rww_block});
		@(posedge i_mclk);
		i_eeprom_write_strobe <= 1'b0;
		$display("test eeprom done");
		u_cpu.op(8'h09, 1'b0, 0, 16'h0001, 16'h00C3, rd);
		chk("lock_rww", 32'h0, o_rww_block);
		u_cpu.op(8'h09, 1'b1, 0, 16'h0001, 16'h0000, rd);
		chk("lock_set", 32'hC3C3, {rd, o_lock_bits});
		$display("test lock done");
		@(posedge i_mclk);
		i_ce <= 1'b0;
		u_cpu.op(8'h01, 1'b0, 0, 16'h0024, 16'h1111, rd);
		chk("ce_freeze", 32'hFFFFFFFF, o_page_data);
		@(posedge i_mclk);
		i_ce <= 1'b1;
		u_cpu.op(8'h01, 1'b0, 0, 16'h0026, 16'h0F0F, rd);
		chk("ce_resume", 32'h0F0FFFFF, o_page_data);
		@(posedge i_mclk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		#1 chk("rst_mid", 32'h00FFFFFF, {o_ctrl_rdata, o_lock_bits, o_page_data[31:16]});
		$display("test ce_reset done");
		complete_run();
	end
endmodule
